// [hw/rtc_i2c_pkg.sv]
package rtc_i2c_pkg;

  // Fixed bus address 0110010
  localparam logic [6:0] SLAVE_ADDR = 7'h32;
  // Pointer banks that wrap on themselves
  localparam logic [3:0] BANK_FIRST = 4'h1;
  localparam logic [3:0] BANK_LAST  = 4'h3;
  localparam logic [7:0] PTR_RESET  = 8'h00;

  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int TIMEOUT_MS        = 950;
  localparam int TIMEOUT_CYCLES    =
    TIMEOUT_MS * 1000000 / SYS_CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS     = 10000;
  localparam int SCL_QTR_CYCLES    =
    SCL_PERIOD_NS / (4 * SYS_CLK_PERIOD_NS);

  localparam logic [3:0] BIT_LAST_RX = 4'h8;
  localparam logic [3:0] BIT_LAST_TX = 4'h7;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_RX   = 3'h1,
    DEV_ACK  = 3'h3,
    DEV_TX   = 3'h2,
    DEV_MACK = 3'h6
  } dev_state_t;

  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_COND = 2'h1,
    HST_BYTE = 2'h2
  } host_state_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ  = 2'h3
  } cmd_t;

endpackage

// [hw/rtc_i2c_if.sv]
`timescale 1ns/1ps
interface rtc_i2c_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_o_host;
  logic sda_oe_host;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: a line is low only while someone pulls it
  assign scl = !(scl_oe_host && !scl_o_host);
  assign sda = !((sda_oe_host && !sda_o_host) ||
                 (sda_oe_dev && !sda_o_dev));

  modport dev (
    input  scl,
    input  sda,
    output sda_o_dev,
    output sda_oe_dev
  );

  modport host (
    input  scl,
    input  sda,
    output scl_o_host,
    output scl_oe_host,
    output sda_o_host,
    output sda_oe_host
  );
endinterface

// [hw/rtc_i2c_host.sv]
`timescale 1ns/1ps
module rtc_i2c_host #(
  parameter int QTR   = rtc_i2c_pkg::SCL_QTR_CYCLES,
  parameter int LIMIT = rtc_i2c_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Bus
  rtc_i2c_if.host          bus,
  // Command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  rtc_i2c_pkg::cmd_t cmd_kind,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_nack,
  // Answer port
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_ack,
  output logic             overtime
);
  localparam int QW = $clog2(QTR + 1);
  localparam int AW = $clog2(LIMIT + 1);

  rtc_i2c_pkg::host_state_t state_q;
  rtc_i2c_pkg::cmd_t        kind_q;
  logic [1:0]    sda_sync_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0]    qtr_q;
  logic [3:0]    bit_q;
  logic [8:0]    tx_q;
  logic [7:0]    rx_q;
  logic          scl_oe_q;
  logic          sda_oe_q;
  logic          ready_q;
  logic          rsp_valid_q;
  logic [7:0]    rsp_data_q;
  logic          rsp_ack_q;
  logic          open_q;
  logic [AW-1:0] age_q;
  logic          over_q;
  logic          tick;

  assign tick = (qcnt_q == QW'(QTR - 1));

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      sda_sync_q <= 2'h3;
    else
      sda_sync_q <= {sda_sync_q[0], bus.sda};
  end

  // Line sequencing in quarter periods; data moves only while scl is low or in the cycle that pulls scl low
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q     <= rtc_i2c_pkg::HST_IDLE;
      kind_q      <= rtc_i2c_pkg::CMD_START;
      qcnt_q      <= '0;
      qtr_q       <= 2'h0;
      bit_q       <= 4'h0;
      tx_q        <= 9'h1ff;
      rx_q        <= 8'h00;
      scl_oe_q    <= 1'b0;
      sda_oe_q    <= 1'b0;
      ready_q     <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_ack_q   <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      qcnt_q      <= tick ? '0 : qcnt_q + QW'(1);
      unique case (state_q)
        rtc_i2c_pkg::HST_IDLE:
        begin
          qcnt_q <= '0;
          qtr_q  <= 2'h0;
          bit_q  <= 4'h0;
          if (cmd_valid && ready_q)
          begin
            ready_q <= 1'b0;
            kind_q  <= cmd_kind;
            if (cmd_kind == rtc_i2c_pkg::CMD_START)
            begin
              state_q  <= rtc_i2c_pkg::HST_COND;
              sda_oe_q <= 1'b0;
            end
            else if (cmd_kind == rtc_i2c_pkg::CMD_STOP)
            begin
              state_q  <= rtc_i2c_pkg::HST_COND;
              sda_oe_q <= 1'b1;
            end
            else
            begin
              // Read bytes release sda and drive only the acknowledge
              state_q  <= rtc_i2c_pkg::HST_BYTE;
              tx_q     <= (cmd_kind == rtc_i2c_pkg::CMD_WRITE) ?
                          {cmd_data, 1'b1} : {8'hff, cmd_nack};
              sda_oe_q <= (cmd_kind == rtc_i2c_pkg::CMD_WRITE) ?
                          !cmd_data[7] : 1'b0;
              scl_oe_q <= 1'b1;
            end
          end
        end
        rtc_i2c_pkg::HST_COND:
          if (tick)
          begin
            qtr_q <= qtr_q + 2'h1;
            unique case (qtr_q)
              2'h0: scl_oe_q <= 1'b0;
              2'h1:
                sda_oe_q <= (kind_q == rtc_i2c_pkg::CMD_START);
              2'h2: scl_oe_q <= (kind_q == rtc_i2c_pkg::CMD_START);
              2'h3:
              begin
                state_q <= rtc_i2c_pkg::HST_IDLE;
                ready_q <= 1'b1;
              end
            endcase
          end
        rtc_i2c_pkg::HST_BYTE:
          if (tick)
          begin
            qtr_q <= qtr_q + 2'h1;
            unique case (qtr_q)
              2'h0: ;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: ;
              2'h3:
              begin
                scl_oe_q <= 1'b1;
                rx_q     <= {rx_q[6:0], sda_sync_q[1]};
                if (bit_q == rtc_i2c_pkg::BIT_LAST_RX)
                begin
                  state_q     <= rtc_i2c_pkg::HST_IDLE;
                  ready_q     <= 1'b1;
                  rsp_valid_q <= 1'b1;
                  rsp_data_q  <= rx_q;
                  rsp_ack_q   <= !sda_sync_q[1];
                end
                else
                begin
                  bit_q    <= bit_q + 4'h1;
                  tx_q     <= {tx_q[7:0], 1'b1};
                  sda_oe_q <= !tx_q[7];
                end
              end
            endcase
          end
        default: state_q <= rtc_i2c_pkg::HST_IDLE;
      endcase
    end
  end

  // Flags a start or repeated start held open as long as the device timeout
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      open_q <= 1'b0;
      age_q  <= '0;
      over_q <= 1'b0;
    end
    else if (state_q == rtc_i2c_pkg::HST_COND && tick && qtr_q == 2'h3)
    begin
      open_q <= (kind_q == rtc_i2c_pkg::CMD_START);
      age_q  <= '0;
      over_q <= 1'b0;
    end
    else if (open_q && !over_q)
    begin
      age_q  <= age_q + AW'(1);
      over_q <= (age_q == AW'(LIMIT - 1));
    end
  end

  assign bus.scl_o_host  = 1'b0;
  assign bus.sda_o_host  = 1'b0;
  assign bus.scl_oe_host = scl_oe_q;
  assign bus.sda_oe_host = sda_oe_q;
  assign cmd_ready       = ready_q;
  assign rsp_valid       = rsp_valid_q;
  assign rsp_data        = rsp_data_q;
  assign rsp_ack         = rsp_ack_q;
  assign overtime        = over_q;
endmodule

// [hw/rtc_i2c_dev.sv]
`timescale 1ns/1ps
// How it works
// - Idle bus leaves both lines released high
// - Start: sda falls with scl high
// - Stop: sda rises with scl high
// - Start before stop is a repeated start
// - Payload moves in whole bytes
// - No byte count limit per transaction
// - Transaction reaching 0.95 s resets interface
// - Respond only to address 0110010
// - Address byte lsb selects write or read
// - Write: address, pointer, data, all acknowledged
// - Pointer advances after every data byte
// - Pointer wraps inside 16-byte banks 10h-3Fh
// - Random read: pointer write, repeated start, read
// - Read address acked, then send pointed register
// - Master ack low keeps bytes coming
// - Master nack then stop ends read
// - Bare read starts after last accessed address
// - All bus ports open drain only
// - Stop option plus low supply silences interface
module rtc_i2c_dev #(
  parameter int TIMEOUT_CYC = rtc_i2c_pkg::TIMEOUT_CYCLES
) (
  // Clocks and reset
  input  wire logic       sys_clk,
  input  wire logic       link_clk,
  input  wire logic       nrst,
  // Bus
  rtc_i2c_if.dev          bus,
  // Supply supervision
  input  wire logic       interface_stop_on_low_supply,
  input  wire logic       supply_low,
  // Register file side, link_clk domain
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  input  wire logic [7:0] reg_rdata,
  output logic            busy
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  rtc_i2c_pkg::dev_state_t state_q;
  logic [1:0]    scl_sync_q, sda_sync_q, en_sync_q, low_sync_q;
  logic [1:0]    xfer_sync_q;
  logic [2:0]    to_sync_q;
  logic [3:0]    bit_q;
  logic [7:0]    rx_q, tx_q, ptr_q, wdata_q;
  logic          scl_q, sda_q, sda_oe_q, first_q, rw_q, ack_q;
  logic          xfer_q, got_ptr_q, wr_q, fired_q, to_tg_q;
  logic [CW-1:0] to_cnt_q;

  logic          scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic          halt, abort, byte_in, addr_hit;
  logic [7:0]    rx_byte;

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    if (p[7:4] >= rtc_i2c_pkg::BANK_FIRST &&
        p[7:4] <= rtc_i2c_pkg::BANK_LAST)
      next_ptr = {p[7:4], p[3:0] + 4'h1};
    else
      next_ptr = p + 8'h01;
  endfunction

  // Pin and cross-domain synchronisers
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      en_sync_q  <= 2'h0;
      low_sync_q <= 2'h0;
      to_sync_q  <= 3'h0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
      en_sync_q  <= {en_sync_q[0], interface_stop_on_low_supply};
      low_sync_q <= {low_sync_q[0], supply_low};
      to_sync_q  <= {to_sync_q[1:0], to_tg_q};
    end
  end

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;
  assign halt      = en_sync_q[1] && low_sync_q[1];
  assign abort     = halt || (to_sync_q[2] != to_sync_q[1]);
  assign rx_byte   = {rx_q[6:0], sda_s};
  assign byte_in   = (state_q == rtc_i2c_pkg::DEV_RX) && scl_rise &&
                     (bit_q == rtc_i2c_pkg::BIT_LAST_TX);
  assign addr_hit  = (rx_byte[7:1] == rtc_i2c_pkg::SLAVE_ADDR);

  // Bit engine; sda changes are made on scl falls, except that abort releases sda at once
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= rtc_i2c_pkg::DEV_IDLE;
      bit_q    <= 4'h0;
      rx_q     <= 8'h00;
      tx_q     <= 8'hff;
      sda_oe_q <= 1'b0;
      first_q  <= 1'b0;
      rw_q     <= 1'b0;
      ack_q    <= 1'b0;
      xfer_q   <= 1'b0;
    end
    else if (abort || stop_det)
    begin
      state_q  <= rtc_i2c_pkg::DEV_IDLE;
      sda_oe_q <= 1'b0;
      xfer_q   <= 1'b0;
    end
    else if (start_det)
    begin
      // Same handling for a start and a repeated start
      state_q  <= rtc_i2c_pkg::DEV_RX;
      sda_oe_q <= 1'b0;
      bit_q    <= 4'h0;
      first_q  <= 1'b1;
      xfer_q   <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        rtc_i2c_pkg::DEV_IDLE: ;
        rtc_i2c_pkg::DEV_RX:
          if (scl_rise)
          begin
            rx_q  <= rx_byte;
            bit_q <= bit_q + 4'h1;
            if (byte_in)
              ack_q <= !first_q || addr_hit;
            if (byte_in && first_q)
              rw_q <= rx_byte[0];
          end
          else if (scl_fall && bit_q == rtc_i2c_pkg::BIT_LAST_RX)
          begin
            state_q  <= ack_q ? rtc_i2c_pkg::DEV_ACK : rtc_i2c_pkg::DEV_IDLE;
            sda_oe_q <= ack_q;
          end
        rtc_i2c_pkg::DEV_ACK:
          if (scl_fall)
          begin
            bit_q    <= 4'h0;
            first_q  <= 1'b0;
            state_q  <= rw_q ? rtc_i2c_pkg::DEV_TX :
                               rtc_i2c_pkg::DEV_RX;
            tx_q     <= reg_rdata;
            sda_oe_q <= rw_q && !reg_rdata[7];
          end
        rtc_i2c_pkg::DEV_TX:
          if (scl_fall && bit_q == rtc_i2c_pkg::BIT_LAST_TX)
          begin
            state_q  <= rtc_i2c_pkg::DEV_MACK;
            sda_oe_q <= 1'b0;
          end
          else if (scl_fall)
          begin
            bit_q    <= bit_q + 4'h1;
            tx_q     <= {tx_q[6:0], 1'b1};
            sda_oe_q <= !tx_q[6];
          end
        rtc_i2c_pkg::DEV_MACK:
          if (scl_rise && sda_s)
            state_q <= rtc_i2c_pkg::DEV_IDLE;
          else if (scl_fall)
          begin
            state_q  <= rtc_i2c_pkg::DEV_TX;
            bit_q    <= 4'h0;
            tx_q     <= reg_rdata;
            sda_oe_q <= !reg_rdata[7];
          end
        default:
        begin
          state_q  <= rtc_i2c_pkg::DEV_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Register pointer and write strobe
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_q     <= rtc_i2c_pkg::PTR_RESET;
      got_ptr_q <= 1'b0;
      wdata_q   <= 8'h00;
      wr_q      <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      if (start_det)
        got_ptr_q <= 1'b0;
      else if (byte_in && !first_q && !rw_q && !abort && !stop_det)
      begin
        if (!got_ptr_q)
        begin
          ptr_q     <= rx_byte;
          got_ptr_q <= 1'b1;
        end
        else
        begin
          wdata_q <= rx_byte;
          wr_q    <= 1'b1;
        end
      end
      else if (wr_q || (state_q == rtc_i2c_pkg::DEV_MACK && scl_rise &&
                        !abort && !stop_det && !start_det))
        ptr_q <= next_ptr(ptr_q);
    end
  end

  // Transaction age on the system clock
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      xfer_sync_q <= 2'h0;
      to_cnt_q    <= '0;
      fired_q     <= 1'b0;
      to_tg_q     <= 1'b0;
    end
    else
    begin
      xfer_sync_q <= {xfer_sync_q[0], xfer_q};
      if (!xfer_sync_q[1])
      begin
        to_cnt_q <= '0;
        fired_q  <= 1'b0;
      end
      else if (!fired_q && to_cnt_q == CW'(TIMEOUT_CYC - 1))
      begin
        to_tg_q <= !to_tg_q;
        fired_q <= 1'b1;
      end
      else if (!fired_q)
        to_cnt_q <= to_cnt_q + CW'(1);
    end
  end

  assign bus.sda_o_dev  = 1'b0;
  assign bus.sda_oe_dev = sda_oe_q;
  assign reg_addr       = ptr_q;
  assign reg_wdata      = wdata_q;
  assign reg_wr         = wr_q;
  assign busy           = xfer_q;
endmodule

// [sim/rtc_i2c_monitor.sv]
`timescale 1ns/1ps
module rtc_i2c_monitor #(
  parameter int TIMEOUT_CYC = rtc_i2c_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pin drivers
  input wire logic scl_o_host,
  input wire logic scl_oe_host,
  input wire logic sda_o_host,
  input wire logic sda_oe_host,
  input wire logic sda_o_dev,
  input wire logic sda_oe_dev,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       open_q;
  logic [3:0] cnt_q;
  int         age_q;
  logic       start_w;
  logic       stop_w;

  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w  = scl && scl_q && !sda_q && sda;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end

  // Open from start to stop; repeated start keeps the age running
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      open_q <= 1'b0;
    else if (start_w || stop_w)
      open_q <= start_w;

  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      age_q <= 0;
    else
      age_q <= (open_q && !stop_w) ? age_q + 1 : 0;

  // Clock rises since the last start, saturating
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      cnt_q <= 4'h0;
    else if (start_w)
      cnt_q <= 4'h0;
    else if (scl && !scl_q && cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;

  sequence start_hold_s;
    (scl && sda_oe_host)[*4];
  endsequence
  sequence stop_hold_s;
    (scl && !sda_oe_host)[*4];
  endsequence

  open_drain_a: assert property (
    !scl_o_host && !sda_o_host && !sda_o_dev)
    else $error("bus driven high");
  idle_release_a: assert property (
    !open_q |-> !scl_oe_host && !sda_oe_dev)
    else $error("line pulled on idle bus");
  start_form_a: assert property (
    $rose(sda_oe_host) && scl |-> start_hold_s)
    else $error("start not held with clock high");
  stop_form_a: assert property (
    $fell(sda_oe_host) && scl |-> stop_hold_s)
    else $error("stop not held with clock high");
  dev_change_a: assert property (
    $rose(sda_oe_dev) |-> !scl)
    else $error("device pulled data with clock high");
  dev_hold_a: assert property (
    sda_oe_dev && scl && !scl_q |-> sda_oe_dev[*8])
    else $error("device data moved in clock high");
  addr_quiet_a: assert property (
    open_q && cnt_q < 4'h8 |-> !sda_oe_dev)
    else $error("device drove during address byte");
  timeout_release_a: assert property (
    age_q > TIMEOUT_CYC + 100 |-> !sda_oe_dev)
    else $error("device active after timeout");
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int LIM = 2000;
  logic              sys_clk;
  logic              link_clk;
  logic              nrst;
  logic              cmd_valid;
  logic              cmd_ready;
  rtc_i2c_pkg::cmd_t cmd_kind;
  logic [7:0]        cmd_data;
  logic              cmd_nack;
  logic              rsp_valid;
  logic [7:0]        rsp_data;
  logic              rsp_ack;
  logic              overtime;
  logic              interface_stop_on_low_supply;
  logic              supply_low;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              busy;
  logic [7:0]        mem [256];
  int                err_count;
  int                checks;

  rtc_i2c_if u_rtc_i2c_if ();
  rtc_i2c_host #(.QTR(8), .LIMIT(LIM)) u_rtc_i2c_host (
    .sys_clk(sys_clk), .nrst(nrst), .bus(u_rtc_i2c_if.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack), .overtime(overtime));
  rtc_i2c_dev #(.TIMEOUT_CYC(LIM)) u_rtc_i2c_dev (
    .sys_clk(sys_clk), .link_clk(link_clk), .nrst(nrst),
    .bus(u_rtc_i2c_if.dev),
    .interface_stop_on_low_supply(interface_stop_on_low_supply),
    .supply_low(supply_low), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(mem[reg_addr]), .busy(busy));
  rtc_i2c_monitor #(.TIMEOUT_CYC(LIM)) u_rtc_i2c_monitor (
    .sys_clk(sys_clk), .nrst(nrst),
    .scl_o_host(u_rtc_i2c_if.scl_o_host),
    .scl_oe_host(u_rtc_i2c_if.scl_oe_host),
    .sda_o_host(u_rtc_i2c_if.sda_o_host),
    .sda_oe_host(u_rtc_i2c_if.sda_oe_host),
    .sda_o_dev(u_rtc_i2c_if.sda_o_dev),
    .sda_oe_dev(u_rtc_i2c_if.sda_oe_dev),
    .scl(u_rtc_i2c_if.scl), .sda(u_rtc_i2c_if.sda));

  // Register file standing behind the device
  always @(posedge link_clk)
    if (reg_wr)
      mem[reg_addr] <= reg_wdata;

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end

  task automatic report_and_stop;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (cmd_ready !== 1'b1)
      err_count++;
  endtask

  task automatic xfer(input rtc_i2c_pkg::cmd_t k, input logic [7:0] d,
                      input logic nk);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_data = d;
    cmd_nack = nk;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    wait_ready();
  endtask

  task automatic wr(input logic [7:0] d, input logic a);
    xfer(rtc_i2c_pkg::CMD_WRITE, d, 1'b0);
    chk({6'h00, rsp_valid, rsp_ack}, {6'h00, 1'b1, a});
  endtask

  task automatic rd(input logic nk, input logic [7:0] e);
    xfer(rtc_i2c_pkg::CMD_READ, 8'h00, nk);
    chk(rsp_data, e);
    chk({6'h00, rsp_valid, rsp_ack}, {6'h00, 1'b1, !nk});
  endtask

  task automatic sta;
    xfer(rtc_i2c_pkg::CMD_START, 8'h00, 1'b0);
  endtask

  task automatic sto;
    xfer(rtc_i2c_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic t_write;
    logic [7:0] top;
    for (int b = 1; b < 4; b++)
    begin
      top = {b[3:0], 4'hf};
      sta();
      wr(8'h64, 1'b1);
      wr(top, 1'b1);
      wr(8'ha0 + 8'(b), 1'b1);
      wr(8'hb0 + 8'(b), 1'b1);
      sto();
      chk(mem[top], 8'ha0 + 8'(b));
      chk(mem[{b[3:0], 4'h0}], 8'hb0 + 8'(b));
    end
    $display("write done");
  endtask

  task automatic t_reads;
    sta();
    wr(8'h64, 1'b1);
    wr(8'h1f, 1'b1);
    sta();
    wr(8'h65, 1'b1);
    rd(1'b0, 8'ha1);
    rd(1'b0, 8'hb1);
    rd(1'b1, 8'h11 ^ 8'h5a);
    sto();
    sta();
    wr(8'h65, 1'b1);
    rd(1'b0, 8'h12 ^ 8'h5a);
    rd(1'b1, 8'h13 ^ 8'h5a);
    sto();
    $display("reads done");
  endtask

  task automatic t_foreign;
    sta();
    wr(8'h66, 1'b0);
    wr(8'h10, 1'b0);
    sto();
    sta();
    wr(8'he4, 1'b0);
    wr(8'h77, 1'b0);
    sto();
    chk(mem[8'h10], 8'hb1);
    $display("foreign done");
  endtask

  task automatic t_halt;
    for (int m = 0; m < 5; m++)
    begin
      interface_stop_on_low_supply = (m == 1 || m == 3);
      supply_low = (m >= 2 && m < 4);
      repeat (10) @(negedge sys_clk);
      sta();
      wr(8'h64, m != 3);
      sto();
    end
    $display("halt done");
  endtask

  task automatic t_timeout;
    sta();
    wr(8'h64, 1'b1);
    chk({6'h00, overtime, busy}, 8'h01);
    repeat (LIM + 300) @(negedge sys_clk);
    chk({7'h00, overtime}, 8'h01);
    wr(8'h12, 1'b0);
    sto();
    chk({7'h00, overtime, busy}, 8'h00);
    sta();
    wr(8'h64, 1'b1);
    sto();
    $display("timeout done");
  endtask

  initial
  begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = rtc_i2c_pkg::CMD_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    interface_stop_on_low_supply = 1'b0;
    supply_low = 1'b0;
    err_count = 0;
    checks = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({6'h00, u_rtc_i2c_if.scl, u_rtc_i2c_if.sda}, 8'h03);
    chk(reg_addr, 8'h00);
    chk({5'h00, cmd_ready, busy, overtime}, 8'h04);
    $display("reset done");
    t_write();
    t_reads();
    t_foreign();
    t_halt();
    t_timeout();
    report_and_stop();
  end
endmodule
